// [hw/lolc_cfg.svh]
// Constants for the loop oscillator lock controller
// Contract
// - Calibration hitting limit while locking flags out-of-bounds
// - Closed loop ready only after fine lock
// - Re-enable ignores stored fine value
// - Lose-lock-after-wake keeps lock after disable
// - PLL may report false unlocks, low reference
// - Bypass lets PLL clock pass while unlocked
// - Clock ready shows output activity only
// - On-the-fly ratio change leaves status clear
`ifndef LOLC_CFG_SVH
`define LOLC_CFG_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define LOLC_A_FCTRLA  8'h00
`define LOLC_A_FCFGB   8'h04
`define LOLC_A_FMUL    8'h08
`define LOLC_A_FVAL    8'h0C
`define LOLC_A_PCTRL   8'h10
`define LOLC_A_PRATIO  8'h14
`define LOLC_A_STATUS  8'h18
`define LOLC_A_IFLAG   8'h1C
`define LOLC_A_ICLR    8'h20
`define LOLC_A_IEN     8'h24
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LOLC_B_EN      0
`define LOLC_B_LOSE_LOCK_AFTER_WAKE    1
`define LOLC_B_CLOSED  0
`define LOLC_B_LBYP    1
`define LOLC_B_WUF     2
`define LOLC_B_FINE_LO 0
`define LOLC_B_CRS_LO  8
`define LOLC_I_CLOCK   0
`define LOLC_I_FLOCK   1
`define LOLC_I_BOUND   2
`define LOLC_I_FRDY    3
`define LOLC_I_PLOCK   4
`define LOLC_I_PUNLK   5
`define LOLC_I_RDONE   6
// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define LOLC_FINE_MID  8'h80
`define LOLC_CRS_MID   6'h20
`define LOLC_RATIO_RST 12'h000
`define LOLC_LOSE_LOCK_AFTER_WAKE_HOLD 8'h10
`define LOLC_RLD_TICKS 8'h04
`endif

// [hw/lolc_pkg.sv]
// Types for the loop oscillator lock controller
package lolc_pkg;
   typedef enum logic [2:0] {
      FLL_OFF, FLL_OPEN, FLL_COARSE, FLL_FINE, FLL_LOCKED
   } lolc_fst_type;

   typedef struct packed {
      logic         ack;
      logic [31:0]  dat;
      logic [1:0]   err_a;
      logic [1:0]   err_b;
      logic         ftk_a;
      logic         ftk_b;
      logic         ftk_c;
      logic         ptk_a;
      logic         ptk_b;
      logic         ptk_c;
      logic         plk_a;
      logic         plk_b;
      logic         pact_a;
      logic         pact_b;
      logic         en;
      logic         lose_lock_after_wake;
      logic         closed;
      logic         was_en;
      logic [15:0]  mul;
      logic [5:0]   coarse;
      logic [7:0]   fine;
      lolc_fst_type fst;
      logic [1:0]   last_dir;
      logic         lock;
      logic         rdy;
      logic [7:0]   hold;
      logic         pen;
      logic         lbyp;
      logic         pll_wake_up_fast;
      logic         plock;
      logic         pll_clock_ready;
      logic         gate;
      logic [11:0]  ratio;
      logic [11:0]  ratio_out;
      logic         rpend;
      logic [7:0]   rcnt;
      logic         rstat;
      logic [6:0]   flag;
      logic [6:0]   ien;
      logic         irq;
   } lolc_state_type;
endpackage : lolc_pkg

// [hw/lolc_top.sv]
// Lock and status logic for the frequency-locked loop and fractional PLL
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`include "lolc_cfg.svh"

module lolc_top (
   input  wire logic        clk_i,          // 20 MHz bus clock
   input  wire logic        rst_i,          // Synchronous reset, high
   input  wire logic        cyc_i,          // Wishbone cycle
   input  wire logic        stb_i,          // Wishbone strobe
   input  wire logic        we_i,           // Wishbone write
   input  wire logic [7:0]  adr_i,          // Byte address
   input  wire logic [3:0]  sel_i,          // Byte enables
   input  wire logic [31:0] dat_i,          // Write data
   output logic      [31:0] dat_o,          // Read data
   output logic             ack_o,          // Wishbone acknowledge
   input  wire logic [1:0]  fll_err_i,      // Pin: [1] too slow, [0] too fast
   input  wire logic        fll_ref_i,      // Pin: FLL reference clock
   input  wire logic        pll_ref_i,      // Pin: PLL reference clock
   input  wire logic        pll_lock_raw_i, // Pin: PLL lock detector
   input  wire logic        pll_active_i,   // Pin: PLL output activity
   output logic             fll_en_o,       // FLL oscillator enable
   output logic      [5:0]  fll_coarse_o,   // Coarse calibration
   output logic      [7:0]  fll_fine_o,     // Fine calibration
   output logic             pll_en_o,       // PLL enable
   output logic             pll_gate_o,     // PLL output clock gate
   output logic      [11:0] pll_ratio_o,    // Active PLL ratio
   output logic             irq_o           // Level interrupt
);
   lolc_pkg::lolc_state_type s;
   lolc_pkg::lolc_state_type n;

   logic        req;
   logic        wr;
   logic        ftick;
   logic        ptick;
   logic [31:0] wm;
   logic [6:0]  ev;
   logic [31:0] rd;

   // ---------------------------------------------------------------
   // Bus decode and event sources
   // ---------------------------------------------------------------
   // Request taken once; ack drops the cycle after it is given
   assign req   = cyc_i && stb_i && !s.ack;
   assign wr    = req && we_i;
   assign ftick = s.ftk_b && !s.ftk_c;
   assign ptick = s.ptk_b && !s.ptk_c;
   assign wm    = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

   // Read mux; reserved bits read as zero
   always_comb
   begin
      rd = 32'h0000_0000;
      case (adr_i)
         `LOLC_A_FCTRLA: rd = {30'h0, s.lose_lock_after_wake, s.en};
         `LOLC_A_FCFGB:  rd = {31'h0, s.closed};
         `LOLC_A_FMUL:   rd = {16'h0, s.mul};
         `LOLC_A_FVAL:   rd = {18'h0, s.coarse, s.fine};
         `LOLC_A_PCTRL:  rd = {29'h0, s.pll_wake_up_fast, s.lbyp, s.pen};
         `LOLC_A_PRATIO: rd = {20'h0, s.ratio};
         `LOLC_A_STATUS: rd = {26'h0, s.rstat, s.rpend, s.pll_clock_ready, s.plock, s.rdy, s.lock};
         `LOLC_A_IFLAG:  rd = {25'h0, s.flag};
         `LOLC_A_IEN:    rd = {25'h0, s.ien};
         default:        rd = 32'h0000_0000;
      endcase
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      n      = s;
      ev     = 7'h00;
      n.ack  = req;
      n.dat  = req && !we_i ? rd : s.dat;

      // Two-flop synchronisers for every pin
      n.err_a  = fll_err_i;
      n.err_b  = s.err_a;
      n.ftk_a  = fll_ref_i;
      n.ftk_b  = s.ftk_a;
      n.ftk_c  = s.ftk_b;
      n.ptk_a  = pll_ref_i;
      n.ptk_b  = s.ptk_a;
      n.ptk_c  = s.ptk_b;
      n.plk_a  = pll_lock_raw_i;
      n.plk_b  = s.plk_a;
      n.pact_a = pll_active_i;
      n.pact_b = s.pact_a;

      // FLL control writes
      if (wr && adr_i == `LOLC_A_FCTRLA && sel_i[0])
      begin
         n.en   = dat_i[`LOLC_B_EN];
         n.lose_lock_after_wake = dat_i[`LOLC_B_LOSE_LOCK_AFTER_WAKE];
         if (dat_i[`LOLC_B_EN] && !s.en)
         begin
            n.was_en = 1'b1;
            // Stored fine value is lost on re-enable
            if (s.was_en)
               n.fine = `LOLC_FINE_MID;
            // A lock that outlived the disable skips the coarse search
            if (!s.closed)
               n.fst = lolc_pkg::FLL_OPEN;
            else if (s.lock)
               n.fst = lolc_pkg::FLL_FINE;
            else
               n.fst = lolc_pkg::FLL_COARSE;
         end
         if (!dat_i[`LOLC_B_EN] && s.en)
         begin
            n.fst  = lolc_pkg::FLL_OFF;
            n.rdy  = 1'b0;
            n.hold = `LOLC_LOSE_LOCK_AFTER_WAKE_HOLD;
            if (!dat_i[`LOLC_B_LOSE_LOCK_AFTER_WAKE])
               n.lock = 1'b0;
         end
      end
      if (wr && adr_i == `LOLC_A_FCFGB && sel_i[0])
         n.closed = dat_i[`LOLC_B_CLOSED];
      if (wr && adr_i == `LOLC_A_FMUL)
         n.mul = (s.mul & ~wm[15:0]) | (dat_i[15:0] & wm[15:0]);
      // Rewriting the value restores a fine start point
      if (wr && adr_i == `LOLC_A_FVAL && sel_i[1:0] == 2'b11)
      begin
         n.fine   = dat_i[`LOLC_B_FINE_LO +: 8];
         n.coarse = dat_i[`LOLC_B_CRS_LO +: 6];
      end

      // Lock held after disable until the hold runs out
      if (s.fst == lolc_pkg::FLL_OFF && s.lock && ftick)
      begin
         if (s.hold == 8'h00)
            n.lock = 1'b0;
         else
            n.hold = s.hold - 8'h01;
      end

      // FLL search on each reference edge
      // Held off in the cycle of a disable, which the search would undo
      if (ftick && n.en)
      begin
         case (s.fst)
            lolc_pkg::FLL_OPEN:
               n.rdy = 1'b1;
            lolc_pkg::FLL_COARSE:
               if (s.err_b == 2'b00 || (s.last_dir != 2'b00 && s.err_b != s.last_dir))
               begin
                  ev[`LOLC_I_CLOCK] = 1'b1;
                  n.fst = lolc_pkg::FLL_FINE;
                  n.last_dir = 2'b00;
               end
               else
               begin
                  n.last_dir = s.err_b;
                  if (s.err_b[1] && s.coarse != 6'h3F)
                     n.coarse = s.coarse + 6'h01;
                  if (s.err_b[0] && s.coarse != 6'h00)
                     n.coarse = s.coarse - 6'h01;
                  // Any touch of a limit raises the flag until software clears it
                  if (n.coarse == 6'h3F || n.coarse == 6'h00)
                     ev[`LOLC_I_BOUND] = 1'b1;
               end
            lolc_pkg::FLL_FINE:
               if (s.err_b == 2'b00 || (s.last_dir != 2'b00 && s.err_b != s.last_dir))
               begin
                  ev[`LOLC_I_FLOCK] = 1'b1;
                  n.fst  = lolc_pkg::FLL_LOCKED;
                  n.lock = 1'b1;
                  n.rdy  = 1'b1;
               end
               else
               begin
                  n.last_dir = s.err_b;
                  if (s.err_b[1] && s.fine != 8'hFF)
                     n.fine = s.fine + 8'h01;
                  if (s.err_b[0] && s.fine != 8'h00)
                     n.fine = s.fine - 8'h01;
                  if (n.fine == 8'hFF || n.fine == 8'h00)
                     ev[`LOLC_I_BOUND] = 1'b1;
               end
            lolc_pkg::FLL_LOCKED:
               n.rdy = 1'b1;
            default:
               n.rdy = s.rdy;
         endcase
      end
      ev[`LOLC_I_FRDY] = n.rdy && !s.rdy;

      // PLL control and status
      if (wr && adr_i == `LOLC_A_PCTRL && sel_i[0])
      begin
         n.pen  = dat_i[`LOLC_B_EN];
         n.lbyp = dat_i[`LOLC_B_LBYP];
         n.pll_wake_up_fast  = dat_i[`LOLC_B_WUF];
      end
      // Raw detector passes unfiltered, glitches and all
      n.plock = s.plk_b;
      ev[`LOLC_I_PLOCK] = s.plk_b && !s.plock;
      ev[`LOLC_I_PUNLK] = !s.plk_b && s.plock;
      // Activity only; says nothing of lock or frequency
      n.pll_clock_ready = s.pen && s.pact_b;
      // Bypass drops lock gating; wake-fast opens until clock ready
      n.gate = s.pen && (s.plock || s.lbyp || (s.pll_wake_up_fast && !s.pll_clock_ready));

      // Ratio reload
      if (wr && adr_i == `LOLC_A_PRATIO && sel_i[1:0] == 2'b11)
      begin
         n.ratio = dat_i[11:0];
         n.rstat = 1'b0;
         if (s.pen && s.plock)
         begin
            n.rpend = 1'b1;
            n.rcnt  = `LOLC_RLD_TICKS;
         end
         else
         begin
            n.ratio_out = dat_i[11:0];
            n.rstat     = 1'b1;
         end
      end
      else if (s.rpend && ptick)
      begin
         if (s.rcnt == 8'h00)
         begin
            // Completion flags the interrupt only, status stays clear
            n.rpend     = 1'b0;
            n.ratio_out = s.ratio;
            ev[`LOLC_I_RDONE] = 1'b1;
         end
         else
            n.rcnt = s.rcnt - 8'h01;
      end

      // Interrupt flags: set wins over clear
      if (wr && adr_i == `LOLC_A_IEN && sel_i[0])
         n.ien = dat_i[6:0];
      if (wr && adr_i == `LOLC_A_ICLR && sel_i[0])
         n.flag = s.flag & ~dat_i[6:0];
      n.flag = n.flag | ev;
      n.irq  = |(n.flag & n.ien);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s           <= '0;
         s.fst       <= lolc_pkg::FLL_OFF;
         s.coarse    <= `LOLC_CRS_MID;
         s.fine      <= `LOLC_FINE_MID;
         s.ratio     <= `LOLC_RATIO_RST;
         s.ratio_out <= `LOLC_RATIO_RST;
      end
      else
         s <= n;
   end

   // Outputs straight from the state register
   assign dat_o        = s.dat;
   assign ack_o        = s.ack;
   assign fll_en_o     = s.en;
   assign fll_coarse_o = s.coarse;
   assign fll_fine_o   = s.fine;
   assign pll_en_o     = s.pen;
   assign pll_gate_o   = s.gate;
   assign pll_ratio_o  = s.ratio_out;
   assign irq_o        = s.irq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // All checks run on the bus clock; reset masks them
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // A search step that lands coarse on a limit leaves the bound flag up
   bound_flag_sticky_a: assert property (
      $past(ftick && !wr && s.fst == lolc_pkg::FLL_COARSE) && $changed(s.coarse)
      && (s.coarse == 6'h3F || s.coarse == 6'h00) |-> s.flag[`LOLC_I_BOUND])
      else $error("coarse limit reached without bound flag");

   ready_after_fine_a: assert property (
      $rose(s.rdy) && s.closed && $past(s.fst) != lolc_pkg::FLL_OPEN
      |-> $past(s.fst) == lolc_pkg::FLL_FINE && s.lock)
      else $error("closed loop ready before fine lock");

   reenable_fine_mid_a: assert property (
      $rose(s.en) && $past(s.was_en) |-> s.fine == `LOLC_FINE_MID)
      else $error("stored fine value kept on re-enable");

   lose_lock_after_wake_lock_hold_a: assert property (
      $fell(s.en) && s.lose_lock_after_wake && $past(s.lock) |-> s.lock ##1 s.lock)
      else $error("lock dropped at once with lose_lock_after_wake set");

   pll_lock_follow_a: assert property (
      s.plk_b != s.plock |=> s.plock == $past(s.plk_b) && s.flag != 7'h00)
      else $error("pll lock status not following detector");

   bypass_gate_open_a: assert property (
      s.pen && s.lbyp && !s.plock ##1 s.pen && s.lbyp |-> s.gate)
      else $error("bypassed clock gated while unlocked");

   pll_clock_ready_activity_a: assert property (
      !s.pact_b || !s.pen |=> !s.pll_clock_ready)
      else $error("clock ready without output activity");

   ratio_done_flag_a: assert property (
      ev[`LOLC_I_RDONE] |=> s.flag[`LOLC_I_RDONE] && !s.rstat && !s.rpend)
      else $error("on-the-fly ratio completion misreported");

   // Answer lasts one cycle, so a held request is not taken twice
   ack_pulse_a: assert property (
      s.ack |=> !s.ack)
      else $error("acknowledge held longer than one cycle");

   // A raised bound flag stays until software clears it
   bound_flag_hold_a: assert property (
      s.flag[`LOLC_I_BOUND]
      && !(wr && adr_i == `LOLC_A_ICLR && sel_i[0] && dat_i[`LOLC_I_BOUND])
      |=> s.flag[`LOLC_I_BOUND])
      else $error("bound flag lost without a clear");

   bound_flag_clear_a: assert property (
      wr && adr_i == `LOLC_A_ICLR && sel_i[0] && dat_i[`LOLC_I_BOUND]
      && !ev[`LOLC_I_BOUND] |=> !s.flag[`LOLC_I_BOUND])
      else $error("bound flag survived a clear");

   closed_ready_lock_a: assert property (
      s.closed && s.rdy && s.fst != lolc_pkg::FLL_OPEN |-> s.lock)
      else $error("closed loop ready without lock");

   lose_lock_after_wake_lock_clear_a: assert property (
      $fell(s.en) && !s.lose_lock_after_wake |-> !s.lock)
      else $error("lock kept after disable without lose_lock_after_wake");

   pll_gate_closed_a: assert property (
      !s.pen |=> !s.gate)
      else $error("pll clock passed while disabled");

   reload_status_quiet_a: assert property (
      s.rpend |-> !s.rstat)
      else $error("reload status set while update pending");
endmodule : lolc_top

// [bench/lolc_tb.sv]
// Self-checking bench for the loop oscillator lock controller
`timescale 1ns/1ns
`include "lolc_cfg.svh"

module tb;
   // ---------------------------------------------------------------
   // Stimulus and observed outputs
   // ---------------------------------------------------------------
   logic        clk_i          = 1'h0;
   logic        rst_i          = 1'h1;
   logic        cyc_i          = 1'h0;
   logic        stb_i          = 1'h0;
   logic        we_i           = 1'h0;
   logic [7:0]  adr_i          = 8'h00;
   logic [3:0]  sel_i          = 4'h0;
   logic [31:0] dat_i          = 32'h00000000;
   logic [1:0]  fll_err_i      = 2'h0;
   logic        fll_ref_i      = 1'h0;
   logic        pll_ref_i      = 1'h0;
   logic        pll_lock_raw_i = 1'h0;
   logic        pll_active_i   = 1'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        fll_en_o;
   logic [5:0]  fll_coarse_o;
   logic [7:0]  fll_fine_o;
   logic        pll_en_o;
   logic        pll_gate_o;
   logic [11:0] pll_ratio_o;
   logic        irq_o;
   logic [31:0] q;
   int          n_mismatch     = 0;
   int          compares       = 0;
   int          cycles         = 0;
   int          n;

   // 50 ns period
   always #25 clk_i = ~clk_i;

   lolc_top dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .fll_err_i(fll_err_i), .fll_ref_i(fll_ref_i), .pll_ref_i(pll_ref_i),
      .pll_lock_raw_i(pll_lock_raw_i), .pll_active_i(pll_active_i),
      .fll_en_o(fll_en_o), .fll_coarse_o(fll_coarse_o), .fll_fine_o(fll_fine_o),
      .pll_en_o(pll_en_o), .pll_gate_o(pll_gate_o), .pll_ratio_o(pll_ratio_o),
      .irq_o(irq_o)
   );

   // ---------------------------------------------------------------
   // Helper tasks
   // ---------------------------------------------------------------
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One classic cycle; the request stands until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'h1 && k < 20);
      if (k >= 20)
         chk({31'h0, ack_o}, 32'h00000001);
      q = dat_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      we_i  <= 1'h0;
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'h1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'h0, a, 32'h00000000);
      chk(q & m, e);
   endtask : rd

   task automatic wt(input int c);
      repeat (c) @(posedge clk_i);
   endtask : wt

   // Reference ticks are slow against the bus clock so the syncs settle
   task automatic tick(input logic pll, input int k);
      repeat (k)
      begin
         @(posedge clk_i);
         if (pll)
            pll_ref_i <= 1'h1;
         else
            fll_ref_i <= 1'h1;
         wt(4);
         if (pll)
            pll_ref_i <= 1'h0;
         else
            fll_ref_i <= 1'h0;
         wt(4);
      end
   endtask : tick

   // Hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         n_mismatch++;
         close_out();
      end
   end

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial
   begin
      wt(20);
      rst_i <= 1'h0;
      wt(1);
      chk({6'h0, fll_coarse_o, fll_fine_o, pll_ratio_o}, 32'h02080000);
      chk({28'h0, fll_en_o, pll_en_o, pll_gate_o, irq_o}, 32'h00000000);
      rd(`LOLC_A_STATUS, 32'hFFFFFFFF, 32'h00000000);
      rd(8'h30, 32'hFFFFFFFF, 32'h00000000);
      wr(`LOLC_A_FMUL, 32'h1234ABCD);
      rd(`LOLC_A_FMUL, 32'hFFFFFFFF, 32'h0000ABCD);
      rd(`LOLC_A_ICLR, 32'hFFFFFFFF, 32'h00000000);
      // Closed loop search driven into a calibration limit
      wr(`LOLC_A_FCFGB, 32'h00000001);
      wr(`LOLC_A_FCTRLA, 32'h00000001);
      chk({31'h0, fll_en_o}, 32'h00000001);
      fll_err_i <= 2'h2;
      n = 0;
      while (fll_coarse_o != 6'h3F && fll_coarse_o != 6'h00 && n < 40)
      begin
         tick(1'h0, 1);
         n++;
      end
      chk({26'h0, fll_coarse_o}, 32'h0000003F);
      rd(`LOLC_A_STATUS, 32'h00000002, 32'h00000000);
      fll_err_i <= 2'h1;
      tick(1'h0, 2);
      rd(`LOLC_A_IFLAG, 32'h00000007, 32'h00000005);
      rd(`LOLC_A_STATUS, 32'h00000003, 32'h00000000);
      fll_err_i <= 2'h0;
      tick(1'h0, 2);
      rd(`LOLC_A_IFLAG, 32'h00000007, 32'h00000007);
      rd(`LOLC_A_STATUS, 32'h00000003, 32'h00000003);
      // Bound interrupt enabled only once both locks are in
      wr(`LOLC_A_IEN, 32'h00000004);
      wt(2);
      chk({31'h0, irq_o}, 32'h00000001);
      wr(`LOLC_A_ICLR, 32'h00000004);
      wt(2);
      chk({31'h0, irq_o}, 32'h00000000);
      rd(`LOLC_A_IFLAG, 32'h00000007, 32'h00000003);
      wr(`LOLC_A_IEN, 32'h00000003);
      wt(2);
      chk({31'h0, irq_o}, 32'h00000001);
      wr(`LOLC_A_IEN, 32'h00000000);
      wt(2);
      chk({31'h0, irq_o}, 32'h00000000);
      // Re-enable forgets the stored fine value until it is rewritten
      wr(`LOLC_A_FVAL, 32'h00001033);
      rd(`LOLC_A_FVAL, 32'h000000FF, 32'h00000033);
      wr(`LOLC_A_FCTRLA, 32'h00000000);
      rd(`LOLC_A_STATUS, 32'h00000001, 32'h00000000);
      wr(`LOLC_A_FMUL, 32'h00005678);
      wr(`LOLC_A_FCFGB, 32'h00000000);
      wr(`LOLC_A_FCTRLA, 32'h00000001);
      chk({24'h0, fll_fine_o}, 32'h00000080);
      rd(`LOLC_A_FVAL, 32'h00003FFF, 32'h00001080);
      tick(1'h0, 1);
      rd(`LOLC_A_STATUS, 32'h00000003, 32'h00000002);
      wr(`LOLC_A_FVAL, 32'h00001055);
      wt(1);
      chk({24'h0, fll_fine_o}, 32'h00000055);
      // Lock held after disable while lose-lock-after-wake is set
      wr(`LOLC_A_FCTRLA, 32'h00000000);
      wr(`LOLC_A_FCFGB, 32'h00000001);
      wr(`LOLC_A_FCTRLA, 32'h00000003);
      tick(1'h0, 3);
      rd(`LOLC_A_STATUS, 32'h00000001, 32'h00000001);
      wr(`LOLC_A_FCTRLA, 32'h00000002);
      rd(`LOLC_A_STATUS, 32'h00000001, 32'h00000001);
      tick(1'h0, 8);
      rd(`LOLC_A_STATUS, 32'h00000001, 32'h00000001);
      // Enable while lock still stands skips the coarse search
      wr(`LOLC_A_ICLR, 32'h00000003);
      wr(`LOLC_A_FCTRLA, 32'h00000003);
      tick(1'h0, 1);
      rd(`LOLC_A_IFLAG, 32'h00000003, 32'h00000002);
      wr(`LOLC_A_FCTRLA, 32'h00000002);
      tick(1'h0, 18);
      rd(`LOLC_A_STATUS, 32'h00000001, 32'h00000000);
      // PLL gate, clock ready and lock glitches
      // Wake-fast opens the gate until clock ready arrives
      wr(`LOLC_A_PCTRL, 32'h00000005);
      wt(2);
      chk({31'h0, pll_gate_o}, 32'h00000001);
      pll_active_i <= 1'h1;
      wt(5);
      chk({30'h0, pll_en_o, pll_gate_o}, 32'h00000002);
      rd(`LOLC_A_STATUS, 32'h0000000C, 32'h00000008);
      // Settle wait after clock ready, far shorter than on silicon
      wt(10);
      wr(`LOLC_A_PCTRL, 32'h00000000);
      wr(`LOLC_A_PCTRL, 32'h00000006);
      wr(`LOLC_A_PCTRL, 32'h00000007);
      wt(2);
      chk({31'h0, pll_gate_o}, 32'h00000001);
      pll_lock_raw_i <= 1'h1;
      wt(5);
      pll_lock_raw_i <= 1'h0;
      wt(3);
      pll_lock_raw_i <= 1'h1;
      chk({31'h0, pll_gate_o}, 32'h00000001);
      wt(5);
      rd(`LOLC_A_IFLAG, 32'h00000030, 32'h00000030);
      rd(`LOLC_A_STATUS, 32'h00000004, 32'h00000004);
      // On-the-fly ratio change completes without the status bit
      wr(`LOLC_A_PCTRL, 32'h00000001);
      wr(`LOLC_A_ICLR, 32'h0000007F);
      wr(`LOLC_A_PRATIO, 32'h00000456);
      rd(`LOLC_A_STATUS, 32'h00000030, 32'h00000010);
      tick(1'h1, 4);
      chk({20'h0, pll_ratio_o}, 32'h00000000);
      tick(1'h1, 1);
      wt(4);
      chk({20'h0, pll_ratio_o}, 32'h00000456);
      rd(`LOLC_A_STATUS, 32'h00000030, 32'h00000000);
      rd(`LOLC_A_IFLAG, 32'h00000040, 32'h00000040);
      wr(`LOLC_A_PCTRL, 32'h00000000);
      wr(`LOLC_A_PRATIO, 32'h00000123);
      wt(1);
      chk({20'h0, pll_ratio_o}, 32'h00000123);
      rd(`LOLC_A_STATUS, 32'h00000020, 32'h00000020);
      close_out();
   end
endmodule : tb
